//--- rtx_pkg.sv
// Summary of operation
// - reset pin low halts everything
// - leaving reset selects interrupt mode 0
// - reset handling starts on pin release
// - nmi high power-on, low manual reset
// - manual reset spares bus and port regs
// - manual reset reverts pins to ports
// - watchdog overflow resets, either type
// - init, clear trace, set global masks
// - fetch reset vector, load program counter
// - block all interrupts until first instruction
// - module stop loads 3FFF, stopped regs hidden
// - trace only in interrupt mode 2
// - trace after every instruction but exception return while flag set
// - trace sets global mask, clears trace
// - interrupts accepted inside trace handler
// - no trace after exception return
// - nmi top, others eight priority levels
// - trap uses vector from opcode 0..3
// - trap flag updates depend on mode
// - word accesses force address bit 0 low
// - push pc and flags except on reset
// - fixed vector numbers per source
// - no interrupt check after reset or flag ops
package rtx_pkg;
    // register map on the plain port
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_CCR = 3'h1;
    localparam logic [2:0] REG_EXR = 3'h2;
    localparam logic [2:0] REG_MSTP = 3'h3;
    localparam logic [2:0] REG_STAT = 3'h4;
    // flag positions
    localparam int CCR_I = 7;
    localparam int CCR_UI = 6;
    localparam int EXR_T = 7;
    // values after reset
    localparam logic [1:0] INTM_0 = 2'h0;
    localparam logic [1:0] INTM_2 = 2'h2;
    localparam logic [7:0] CCR_RST = 8'h80;
    localparam logic [7:0] EXR_RST = 8'h07;
    localparam logic [15:0] MSTP_RST = 16'h3FFF;
    // vector numbers
    localparam logic [6:0] VEC_POR = 7'h00;
    localparam logic [6:0] VEC_MAN = 7'h01;
    localparam logic [6:0] VEC_TRACE = 7'h05;
    localparam logic [6:0] VEC_NMI = 7'h07;
    localparam logic [6:0] VEC_TRAP0 = 7'h08;
    localparam logic [2:0] NMI_LEVEL = 3'h7;
    typedef enum logic [2:0] {
        ST_HOLD = 3'b000,
        ST_INIT = 3'b001,
        ST_VEC = 3'b010,
        ST_FIRST = 3'b011,
        ST_RUN = 3'b100,
        ST_PUSH = 3'b101
    } rtx_state_e;
endpackage

//--- rtx_exc_seq.sv
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module rtx_exc_seq #(
    parameter int PC_W = 24,
    parameter int SP_W = 24
) (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic chip_init_pin_n_in,
    input wire logic nmi_level_in,
    input wire logic wdt_ovf_in,
    input wire logic wdt_por_in,
    input wire logic insn_done_in,
    input wire logic insn_rte_in,
    input wire logic insn_flagop_in,
    input wire logic trap_in,
    input wire logic [1:0] trap_num_in,
    input wire logic [7:0] pop_ccr_in,
    input wire logic [7:0] pop_exr_in,
    input wire logic nmi_req_in,
    input wire logic irq_req_in,
    input wire logic [6:0] irq_vec_in,
    input wire logic [2:0] irq_lvl_in,
    input wire logic push_ack_in,
    input wire logic vec_valid_in,
    input wire logic [PC_W-1:0] vec_data_in,
    input wire logic [SP_W-1:0] sp_in,
    input wire logic periph_acc_in,
    input wire logic [3:0] periph_idx_in,
    input wire logic [2:0] addr_in,
    input wire logic [15:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic cpu_halt_out,
    output logic periph_init_out,
    output logic busio_init_out,
    output logic port_revert_out,
    output logic rst_por_out,
    output logic push_req_out,
    output logic [7:0] push_ccr_out,
    output logic [7:0] push_exr_out,
    output logic [SP_W-1:0] stack_addr_out,
    output logic vec_req_out,
    output logic [9:0] vec_addr_out,
    output logic pc_load_out,
    output logic [PC_W-1:0] pc_out,
    output logic irq_ack_out,
    output logic nmi_ack_out,
    output logic [7:0] ccr_out,
    output logic [7:0] exr_out,
    output logic [1:0] intm_out,
    output logic [15:0] mstp_out,
    output logic periph_grant_out,
    output logic [15:0] rd_data_out
);
    // ------------------------------------------------------------
    // state and decode
    // ------------------------------------------------------------
    rtx_pkg::rtx_state_e state_r, state_nxt;
    logic [6:0] vec_r, vec_nxt;
    logic [1:0] kind_r, kind_nxt; // 0 trace, 1 nmi, 2 irq, 3 trap
    logic [2:0] lvl_r, lvl_nxt;
    logic trap_pend_r;
    logic [1:0] trap_num_r; // kept apart from vec_r, which a winning trace overwrites
    logic rst_seq_r;

    wire mode2 = intm_out == rtx_pkg::INTM_2;
    wire enter_rst = !chip_init_pin_n_in || wdt_ovf_in;
    wire trace_go = mode2 && exr_out[rtx_pkg::EXR_T] && !insn_rte_in;
    wire irq_ok = mode2 ? (irq_lvl_in > exr_out[2:0]) : !ccr_out[rtx_pkg::CCR_I];
    wire irq_go = !insn_flagop_in && (nmi_req_in || (irq_req_in && irq_ok));
    wire trap_go = trap_in || trap_pend_r;
    wire [1:0] trap_sel = trap_in ? trap_num_in : trap_num_r;
    wire take_exc = state_r == rtx_pkg::ST_RUN && insn_done_in && (trace_go || irq_go || trap_go);
    wire fetch_done = state_r == rtx_pkg::ST_VEC && vec_valid_in;
    wire push_done = state_r == rtx_pkg::ST_PUSH && push_ack_in;
    wire sw_wr_ccr = wr_in && addr_in == rtx_pkg::REG_CCR;
    wire sw_wr_exr = wr_in && addr_in == rtx_pkg::REG_EXR;
    wire sw_wr_ctl = wr_in && addr_in == rtx_pkg::REG_CTRL;
    wire sw_wr_mstp = wr_in && addr_in == rtx_pkg::REG_MSTP;
    wire mode_legal = wr_data_in[1:0] == rtx_pkg::INTM_0 || wr_data_in[1:0] == rtx_pkg::INTM_2;
    wire [15:0] rd_mux;

    // next state: reset pin wins over every other source
    always_comb begin
        state_nxt = state_r;
        vec_nxt = vec_r;
        kind_nxt = kind_r;
        lvl_nxt = lvl_r;
        if (enter_rst) begin
            state_nxt = rtx_pkg::ST_HOLD;
        end else begin
            case (state_r)
                rtx_pkg::ST_HOLD: begin
                    state_nxt = rtx_pkg::ST_INIT;
                end
                rtx_pkg::ST_INIT: begin
                    state_nxt = rtx_pkg::ST_VEC;
                    vec_nxt = rst_por_out ? rtx_pkg::VEC_POR : rtx_pkg::VEC_MAN;
                end
                rtx_pkg::ST_VEC: begin
                    if (vec_valid_in) begin
                        state_nxt = rst_seq_r ? rtx_pkg::ST_FIRST : rtx_pkg::ST_RUN;
                    end
                end
                rtx_pkg::ST_FIRST: begin
                    // no acceptance until the first instruction is done
                    if (insn_done_in) begin
                        state_nxt = rtx_pkg::ST_RUN;
                    end
                end
                rtx_pkg::ST_RUN: begin
                    if (take_exc) begin
                        state_nxt = rtx_pkg::ST_PUSH;
                        if (trace_go) begin
                            kind_nxt = 2'h0;
                            vec_nxt = rtx_pkg::VEC_TRACE;
                        end else if (irq_go && nmi_req_in) begin
                            kind_nxt = 2'h1;
                            vec_nxt = rtx_pkg::VEC_NMI;
                            lvl_nxt = rtx_pkg::NMI_LEVEL;
                        end else if (irq_go) begin
                            kind_nxt = 2'h2;
                            vec_nxt = irq_vec_in;
                            lvl_nxt = irq_lvl_in;
                        end else begin
                            kind_nxt = 2'h3;
                            vec_nxt = rtx_pkg::VEC_TRAP0 + {5'h00, trap_sel};
                        end
                    end
                end
                rtx_pkg::ST_PUSH: begin
                    if (push_ack_in) begin
                        state_nxt = rtx_pkg::ST_VEC;
                    end
                end
                default: begin
                    state_nxt = rtx_pkg::ST_HOLD;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r <= rtx_pkg::ST_HOLD;
            vec_r <= rtx_pkg::VEC_POR;
            kind_r <= 2'h0;
            lvl_r <= 3'h0;
        end else begin
            state_r <= state_nxt;
            vec_r <= vec_nxt;
            kind_r <= kind_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    // reset type: pin sampled nmi level, watchdog brings its own type
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_por_out <= 1'b1;
            rst_seq_r <= 1'b1;
        end else begin
            if (!chip_init_pin_n_in) begin
                rst_por_out <= nmi_level_in;
            end else if (wdt_ovf_in) begin
                rst_por_out <= wdt_por_in;
            end
            if (state_nxt == rtx_pkg::ST_HOLD) begin
                rst_seq_r <= 1'b1;
            end else if (fetch_done) begin
                rst_seq_r <= 1'b0;
            end
        end
    end

    // a trap that loses to trace or an interrupt waits its turn
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            trap_pend_r <= 1'b0;
            trap_num_r <= 2'h0;
        end else if (enter_rst) begin
            trap_pend_r <= 1'b0;
        end else if (take_exc && kind_nxt == 2'h3) begin
            trap_pend_r <= 1'b0;
        end else if (insn_done_in && trap_in) begin
            trap_pend_r <= 1'b1;
            trap_num_r <= trap_num_in;
        end
    end

    // ------------------------------------------------------------
    // reset strobes and halt
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cpu_halt_out <= 1'b1;
            periph_init_out <= 1'b0;
            busio_init_out <= 1'b0;
            port_revert_out <= 1'b0;
        end else begin
            cpu_halt_out <= state_nxt == rtx_pkg::ST_HOLD;
            periph_init_out <= state_nxt == rtx_pkg::ST_INIT;
            busio_init_out <= state_nxt == rtx_pkg::ST_INIT && rst_por_out;
            port_revert_out <= state_nxt == rtx_pkg::ST_INIT && !rst_por_out;
        end
    end

    // ------------------------------------------------------------
    // stack push and vector fetch
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            push_req_out <= 1'b0;
            push_ccr_out <= 8'h00;
            push_exr_out <= 8'h00;
            stack_addr_out <= '0;
            vec_req_out <= 1'b0;
            vec_addr_out <= 10'h000;
            pc_load_out <= 1'b0;
            pc_out <= '0;
            irq_ack_out <= 1'b0;
            nmi_ack_out <= 1'b0;
        end else begin
            push_req_out <= state_nxt == rtx_pkg::ST_PUSH && !push_done;
            if (take_exc) begin
                push_ccr_out <= ccr_out; // stacked trace flag keeps its 1
                push_exr_out <= exr_out;
            end
            stack_addr_out <= {sp_in[SP_W-1:1], 1'b0};
            vec_req_out <= state_nxt == rtx_pkg::ST_VEC && !fetch_done;
            vec_addr_out <= {vec_nxt, 3'h0} >> 1; // four bytes per entry
            pc_load_out <= fetch_done;
            if (fetch_done) begin
                pc_out <= vec_data_in;
            end
            irq_ack_out <= take_exc && kind_nxt == 2'h2;
            nmi_ack_out <= take_exc && kind_nxt == 2'h1;
        end
    end

    // ------------------------------------------------------------
    // condition code, extended register and mode
    // ------------------------------------------------------------
    // hardware exception updates beat a software write in the same cycle
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ccr_out <= rtx_pkg::CCR_RST;
            exr_out <= rtx_pkg::EXR_RST;
            intm_out <= rtx_pkg::INTM_0;
        end else if (state_r == rtx_pkg::ST_INIT) begin
            ccr_out[rtx_pkg::CCR_I] <= 1'b1;
            exr_out <= rtx_pkg::EXR_RST;
            intm_out <= rtx_pkg::INTM_0;
        end else if (push_done) begin
            ccr_out[rtx_pkg::CCR_I] <= 1'b1;
            if (mode2) begin
                exr_out[rtx_pkg::EXR_T] <= 1'b0;
                if (kind_r == 2'h1 || kind_r == 2'h2) begin
                    exr_out[2:0] <= lvl_r;
                end
            end
        end else if (state_r == rtx_pkg::ST_RUN && insn_done_in && insn_rte_in) begin
            ccr_out <= pop_ccr_in;
            exr_out <= pop_exr_in;
        end else begin
            if (sw_wr_ccr) begin
                ccr_out <= wr_data_in[7:0];
            end
            if (sw_wr_exr) begin
                exr_out <= {wr_data_in[7], 4'h0, wr_data_in[2:0]};
            end
            if (sw_wr_ctl && mode_legal) begin
                intm_out <= wr_data_in[1:0]; // prohibited codes ignored
            end
        end
    end

    // ------------------------------------------------------------
    // module stop and register port
    // ------------------------------------------------------------
    assign rd_mux = (addr_in == rtx_pkg::REG_CTRL) ? {14'h0000, intm_out} :
                    (addr_in == rtx_pkg::REG_CCR) ? {8'h00, ccr_out} :
                    (addr_in == rtx_pkg::REG_EXR) ? {8'h00, exr_out} :
                    (addr_in == rtx_pkg::REG_MSTP) ? mstp_out :
                    (addr_in == rtx_pkg::REG_STAT) ? {12'h000, rst_por_out, state_r} : 16'h0000;

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mstp_out <= rtx_pkg::MSTP_RST;
            periph_grant_out <= 1'b0;
            rd_data_out <= 16'h0000;
        end else begin
            if (state_r == rtx_pkg::ST_INIT) begin
                mstp_out <= rtx_pkg::MSTP_RST;
            end else if (sw_wr_mstp) begin
                mstp_out <= wr_data_in;
            end
            periph_grant_out <= periph_acc_in && !mstp_out[periph_idx_in];
            rd_data_out <= rd_in ? rd_mux : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_release;
        $rose(chip_init_pin_n_in) && !wdt_ovf_in;
    endsequence
    sequence s_init_then_fetch;
        periph_init_out ##1 vec_req_out;
    endsequence

    property p_halt_low;
        @(posedge mclk_in) disable iff (!rst_b_in)
        !chip_init_pin_n_in |=> cpu_halt_out && !pc_load_out;
    endproperty
    a_halt_low: assert property (p_halt_low) else $error("not halted under reset pin");

    property p_release_seq;
        @(posedge mclk_in) disable iff (!rst_b_in)
        s_release |=> s_init_then_fetch;
    endproperty
    a_release_seq: assert property (p_release_seq) else $error("release sequence wrong");

    property p_init_flags;
        @(posedge mclk_in) disable iff (!rst_b_in)
        periph_init_out |=> intm_out == 2'h0 && ccr_out[7] && !exr_out[7] && mstp_out == 16'h3FFF;
    endproperty
    a_init_flags: assert property (p_init_flags) else $error("reset flags wrong");

    property p_reset_vec;
        @(posedge mclk_in) disable iff (!rst_b_in)
        periph_init_out |=> vec_addr_out == (rst_por_out ? 10'h000 : 10'h004);
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("reset vector wrong");

    property p_manual_spares;
        @(posedge mclk_in) disable iff (!rst_b_in)
        periph_init_out && !rst_por_out |-> !busio_init_out && port_revert_out;
    endproperty
    a_manual_spares: assert property (p_manual_spares) else $error("manual reset touched bus");

    property p_trace_mode0;
        @(posedge mclk_in) disable iff (!rst_b_in)
        intm_out == 2'h0 && state_r == rtx_pkg::ST_RUN |=> !(push_req_out && vec_r == 7'h05);
    endproperty
    a_trace_mode0: assert property (p_trace_mode0) else $error("trace in mode 0");

    property p_no_trace_rte;
        @(posedge mclk_in) disable iff (!rst_b_in)
        state_r == rtx_pkg::ST_RUN && insn_done_in && insn_rte_in && !irq_go && !trap_go
        |=> state_r != rtx_pkg::ST_PUSH;
    endproperty
    a_no_trace_rte: assert property (p_no_trace_rte) else $error("trace after return");

    property p_first_blocked;
        @(posedge mclk_in) disable iff (!rst_b_in)
        state_r == rtx_pkg::ST_FIRST |=> !irq_ack_out && !nmi_ack_out;
    endproperty
    a_first_blocked: assert property (p_first_blocked) else $error("interrupt before first insn");

    property p_stack_even;
        @(posedge mclk_in) disable iff (!rst_b_in)
        ##1 1'b1 |-> !stack_addr_out[0];
    endproperty
    a_stack_even: assert property (p_stack_even) else $error("odd stack address");

    property p_push_flags;
        @(posedge mclk_in) disable iff (!rst_b_in)
        push_done && intm_out == 2'h2 |=> ccr_out[7] && !exr_out[7];
    endproperty
    a_push_flags: assert property (p_push_flags) else $error("exception flags wrong");
endmodule

//--- rtx_partner.sv
`timescale 1ns/1ns
// cpu core stand-in: answers stack pushes and vector fetches after a chosen delay
module rtx_partner (
    input wire logic mclk_in,
    input wire logic [1:0] dly_in,
    input wire logic push_req_in,
    input wire logic vec_req_in,
    input wire logic [9:0] vec_addr_in,
    output logic push_ack_out = 1'b0,
    output logic vec_valid_out = 1'b0,
    output logic [23:0] vec_data_out = 24'h5A5A5A
);
    logic [1:0] pcnt_r = 2'h0;
    logic [1:0] vcnt_r = 2'h0;
    // -----------------------------------------
    // handshakes
    // -----------------------------------------
    // one ack pulse per request; >= so a delay change mid-wait cannot hang the push
    always @(posedge mclk_in) begin
        if (push_ack_out) begin
            push_ack_out <= 1'b0;
            pcnt_r <= 2'h0;
        end else if (push_req_in) begin
            if (pcnt_r >= dly_in) begin
                push_ack_out <= 1'b1;
            end else begin
                pcnt_r <= pcnt_r + 2'h1;
            end
        end
    end
    // vector data toggles outside the valid cycle so a stale word never matches
    always @(posedge mclk_in) begin
        if (vec_valid_out) begin
            vec_valid_out <= 1'b0;
            vcnt_r <= 2'h0;
            vec_data_out <= ~vec_data_out;
        end else if (vec_req_in && vcnt_r >= dly_in) begin
            vec_valid_out <= 1'b1;
            vec_data_out <= {14'h2800, vec_addr_in};
        end else begin
            vcnt_r <= vec_req_in ? vcnt_r + 2'h1 : vcnt_r;
            vec_data_out <= ~vec_data_out;
        end
    end
endmodule

//--- rtx_exc_seq_tb_top.sv
`timescale 1ns/1ns
module rtx_exc_seq_tb_top;
    // -----------------------------------------
    // stimulus and observed signals
    // -----------------------------------------
    logic mclk_in = 1'b0, rst_b_in = 1'b0, chip_init_pin_n_in = 1'b0, nmi_level_in = 1'b1;
    logic wdt_ovf_in = 1'b0, wdt_por_in = 1'b0, insn_done_in = 1'b0, insn_rte_in = 1'b0;
    logic insn_flagop_in = 1'b0, trap_in = 1'b0, nmi_req_in = 1'b0, irq_req_in = 1'b0;
    logic periph_acc_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, rd_d = 1'b0;
    logic [1:0] trap_num_in = 2'h0, dly = 2'h0;
    logic [7:0] pop_ccr_in = 8'h00, pop_exr_in = 8'h00;
    logic [6:0] irq_vec_in = 7'h10;
    logic [2:0] irq_lvl_in = 3'h0, addr_in = 3'h0;
    logic [3:0] periph_idx_in = 4'h0;
    logic [15:0] wr_data_in = 16'h0000, seed = 16'hD3C3;
    logic [23:0] sp_in = 24'h00FF13, exp_pc = 24'h000000;
    logic push_ack_in, vec_valid_in, cpu_halt_out, busio_init_out, port_revert_out, push_req_out;
    logic vec_req_out, pc_load_out, periph_grant_out, irq_ack_out, nmi_ack_out;
    logic [23:0] vec_data_in, stack_addr_out, pc_out;
    logic [9:0] vec_addr_out;
    logic [15:0] rd_data_out;
    logic [9:0] vq[$];
    logic [15:0] rq[$];
    int err_total = 0, num_checks = 0, n_busio = 0, n_revert = 0, n_nmi = 0, n_irq = 0;

    always #25 mclk_in = ~mclk_in;

    rtx_exc_seq i_rtx_exc_seq (.mclk_in, .rst_b_in, .chip_init_pin_n_in, .nmi_level_in, .wdt_ovf_in,
        .wdt_por_in, .insn_done_in, .insn_rte_in, .insn_flagop_in, .trap_in, .trap_num_in, .pop_ccr_in,
        .pop_exr_in, .nmi_req_in, .irq_req_in, .irq_vec_in, .irq_lvl_in, .push_ack_in, .vec_valid_in,
        .vec_data_in, .sp_in, .periph_acc_in, .periph_idx_in, .addr_in, .wr_data_in, .wr_in, .rd_in,
        .cpu_halt_out, .periph_init_out(), .busio_init_out, .port_revert_out, .rst_por_out(),
        .push_req_out, .push_ccr_out(), .push_exr_out(), .stack_addr_out, .vec_req_out, .vec_addr_out,
        .pc_load_out, .pc_out, .irq_ack_out, .nmi_ack_out, .ccr_out(), .exr_out(), .intm_out(),
        .mstp_out(), .periph_grant_out, .rd_data_out);

    rtx_partner i_rtx_partner (.mclk_in(mclk_in), .dly_in(dly), .push_req_in(push_req_out),
        .vec_req_in(vec_req_out), .vec_addr_in(vec_addr_out), .push_ack_out(push_ack_in),
        .vec_valid_out(vec_valid_in), .vec_data_out(vec_data_in));

    // -----------------------------------------
    // helpers
    // -----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        {addr_in, wr_data_in, wr_in} <= {a, d, 1'b1};
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, input logic [15:0] e);
        @(posedge mclk_in);
        {addr_in, rd_in} <= {a, 1'b1};
        rq.push_back(e);
        @(posedge mclk_in);
        rd_in <= 1'b0;
    endtask
    // partner delay is reshuffled per instruction so fast and slow answers both occur
    task automatic insn(input logic r, input logic f, input logic t, input logic [1:0] n);
        @(posedge mclk_in);
        seed = lfsr(seed);
        dly <= seed[1:0];
        {insn_done_in, insn_rte_in, insn_flagop_in, trap_in, trap_num_in} <= {1'b1, r, f, t, n};
        @(posedge mclk_in);
        {insn_done_in, insn_rte_in, insn_flagop_in, trap_in} <= 4'h0;
    endtask
    task automatic wait_pc();
        int k;
        for (k = 0; k < 60; k++) begin
            @(negedge mclk_in);
            if (pc_load_out === 1'b1) break;
        end
        if (k == 60) begin
            chk(24'(pc_load_out), 24'h000001);
            tally_and_finish();
        end
    endtask
    task automatic exc(input logic [9:0] va, input logic t, input logic [1:0] n);
        vq.push_back(va);
        insn(1'b0, 1'b0, t, n);
        wait_pc();
    endtask
    task automatic quiet(input logic r, input logic f);
        insn(r, f, 1'b0, 2'h0);
        repeat (4) begin
            @(negedge mclk_in);
            chk(24'(push_req_out), 24'h000000);
        end
    endtask
    task automatic pin_reset(input logic lvl, input logic [9:0] va);
        @(posedge mclk_in);
        {chip_init_pin_n_in, nmi_level_in} <= {1'b0, lvl};
        repeat (20) @(posedge mclk_in); // held low 20 states
        @(negedge mclk_in);
        chk(24'(cpu_halt_out), 24'h000001);
        chk(24'(vec_req_out), 24'h000000);
        vq.push_back(va);
        @(posedge mclk_in);
        chip_init_pin_n_in <= 1'b1;
        wait_pc();
    endtask
    task automatic wdt_reset(input logic por, input logic [9:0] va);
        vq.push_back(va);
        @(posedge mclk_in);
        {wdt_ovf_in, wdt_por_in} <= {1'b1, por};
        @(posedge mclk_in);
        wdt_ovf_in <= 1'b0;
        wait_pc();
    endtask
    task automatic grant_chk(input logic [3:0] i, input logic e);
        @(posedge mclk_in);
        {periph_acc_in, periph_idx_in} <= {1'b1, i};
        @(posedge mclk_in);
        periph_acc_in <= 1'b0;
        @(negedge mclk_in);
        chk(24'(periph_grant_out), 24'(e));
    endtask

    // -----------------------------------------
    // scoreboard
    // -----------------------------------------
    // oldest note meets each read answer and each vector fetch; empty queue forces a mismatch
    always @(posedge mclk_in) begin
        if (rd_d) chk(24'(rd_data_out), rq.size() > 0 ? 24'(rq.pop_front()) : 24'hFFFFFF);
        rd_d <= rd_in;
        if (vec_req_out === 1'b1 && vec_valid_in === 1'b1) begin
            exp_pc = {14'h2800, vq.size() > 0 ? vq.pop_front() : 10'h3FF};
            chk(24'(vec_addr_out), 24'(exp_pc[9:0]));
        end
        if (pc_load_out === 1'b1) chk(pc_out, exp_pc);
        if (push_req_out === 1'b1 && push_ack_in === 1'b1) chk(stack_addr_out, {sp_in[23:1], 1'b0});
        if (busio_init_out === 1'b1) n_busio++;
        if (port_revert_out === 1'b1) n_revert++;
        if (nmi_ack_out === 1'b1) n_nmi++;
        if (irq_ack_out === 1'b1) n_irq++;
    end

    // -----------------------------------------
    // sequence
    // -----------------------------------------
    initial begin
        repeat (30000) @(posedge mclk_in);
        err_total++;
        tally_and_finish();
    end
    initial begin
        logic [2:0] m;
        logic [6:0] v;
        repeat (12) @(posedge mclk_in);
        seed = lfsr(seed);
        rst_b_in <= 1'b1;
        sp_in <= {seed, 8'h13};
        pin_reset(1'b1, 10'h000);
        rd_reg(rtx_pkg::REG_CTRL, 16'h0000);
        rd_reg(rtx_pkg::REG_CCR, 16'h0080);
        rd_reg(rtx_pkg::REG_EXR, 16'h0007);
        rd_reg(rtx_pkg::REG_MSTP, 16'h3FFF);
        nmi_req_in <= 1'b1;
        quiet(1'b0, 1'b0);
        exc(10'h01C, 1'b0, 2'h0);
        quiet(1'b0, 1'b1);
        exc(10'h01C, 1'b0, 2'h0);
        @(posedge mclk_in);
        nmi_req_in <= 1'b0;
        wr_reg(rtx_pkg::REG_CCR, 16'h0040);
        wr_reg(rtx_pkg::REG_EXR, 16'h0080);
        quiet(1'b0, 1'b0);
        for (int n = 0; n < 4; n++) exc(10'h020 + 10'(4 * n), 1'b1, 2'(n));
        rd_reg(rtx_pkg::REG_CCR, 16'h00C0);
        rd_reg(rtx_pkg::REG_EXR, 16'h0080);
        wr_reg(rtx_pkg::REG_CCR, 16'h0000);
        seed = lfsr(seed);
        v = 7'(16'h0010 + seed % 16'h0048);
        m = seed[5:3];
        @(posedge mclk_in);
        {irq_req_in, irq_vec_in, irq_lvl_in} <= {1'b1, v, seed[2:0]};
        exc({v, 2'b00}, 1'b0, 2'h0);
        @(posedge mclk_in);
        irq_req_in <= 1'b0;
        wr_reg(rtx_pkg::REG_CTRL, 16'h0002);
        wr_reg(rtx_pkg::REG_CTRL, 16'h0001);
        rd_reg(rtx_pkg::REG_CTRL, 16'h0002);
        wr_reg(rtx_pkg::REG_EXR, {8'h00, 5'h10, m});
        wr_reg(rtx_pkg::REG_CCR, 16'h0040);
        exc(10'h014, 1'b0, 2'h0);
        rd_reg(rtx_pkg::REG_EXR, {13'h0000, m});
        rd_reg(rtx_pkg::REG_CCR, 16'h00C0);
        @(posedge mclk_in);
        {pop_exr_in, pop_ccr_in} <= {5'h10, m, 8'h40};
        quiet(1'b1, 1'b0);
        rd_reg(rtx_pkg::REG_EXR, {8'h00, 5'h10, m});
        exc(10'h014, 1'b0, 2'h0);
        wr_reg(rtx_pkg::REG_CCR, 16'h0040);
        exc(10'h028, 1'b1, 2'h2);
        rd_reg(rtx_pkg::REG_CCR, 16'h00C0);
        rd_reg(rtx_pkg::REG_EXR, {13'h0000, m});
        grant_chk(4'h3, 1'b0);
        grant_chk(4'hE, 1'b1);
        wr_reg(rtx_pkg::REG_MSTP, 16'h0000);
        grant_chk(4'h3, 1'b1);
        pin_reset(1'b0, 10'h004);
        rd_reg(rtx_pkg::REG_MSTP, 16'h3FFF);
        rd_reg(rtx_pkg::REG_STAT, 16'h0003);
        chk(24'(n_nmi), 24'h000002);
        chk(24'(n_irq), 24'h000001);
        rd_reg(rtx_pkg::REG_CTRL, 16'h0000);
        chk(24'(n_revert), 24'h000001);
        chk(24'(n_busio), 24'h000001);
        wdt_reset(1'b0, 10'h004);
        wdt_reset(1'b1, 10'h000);
        chk(24'(n_busio), 24'h000002);
        repeat (4) @(posedge mclk_in);
        tally_and_finish();
    end
endmodule
